// ---- rtl/iufr_pkg.sv ----
// Package for the input undervoltage fault response sequencer
package iufr_pkg;
    localparam int CLK_MHZ = 250;
    localparam logic [7:0] ACTION_OFFSET = 8'h5A;
    localparam logic [7:0] THRESHOLD_OFFSET = 8'h59;
    localparam logic [7:0] ACTION_RESET = 8'h00;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [2:0] RETRY_INFINITE = 3'h7;
    localparam int SHUTDOWN_MS_BASE = 10;
    localparam int RESTART_MS_BASE = 252;
    localparam int RESTART_MS_STEP = 336;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int TIMER_W = 30;

    typedef enum logic [1:0] {
        IUFR_IGNORE = 2'h0,
        IUFR_RIDE = 2'h1,
        IUFR_SHUT = 2'h2,
        IUFR_HOLD = 2'h3
    } iufr_mode_type;

    typedef struct packed {
        iufr_mode_type mode;
        logic [2:0] retries;
        logic [2:0] delay;
    } iufr_action_type;

    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [15:0] wdata;
    } iufr_reg_wr_type;
endpackage : iufr_pkg

// ---- rtl/iufr_timer.sv ----
// Down-counting clock-cycle timer with a load strobe and a done flag
module iufr_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [iufr_pkg::TIMER_W-1:0] cycles,
    output logic done
);
    logic [iufr_pkg::TIMER_W-1:0] count_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= cycles;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign done = (count_r == '0) && !load;
endmodule : iufr_timer

// ---- rtl/iufr_seq.sv ----
// Input undervoltage fault response sequencer with its two registers
// Behaviour
// - Bits 7:6 pick the response, and 00 ignores the undervoltage fault.
// - Response 01 keeps running for the shutdown delay, then shuts down and retries.
// - Response 10 shuts down at once, disables the output and retries.
// - Response 11 holds the output off while the fault lasts and restores it after.
// - Bits 5:3 give zero to six retries, and 111 retries without limit.
// - Bits 2:0 give a shutdown delay of 10 ms doubled per code up to 1280 ms.
// - Bits 2:0 give a restart spacing of 252 ms plus 336 ms per code up to 2604 ms.
// - With retries used up and the fault present the output stays off until reset.
// - A fault is a measured input voltage below the threshold at register 0x59.
module iufr_seq (
    input wire logic mclk,
    input wire logic rst,
    input iufr_pkg::iufr_reg_wr_type reg_wr,
    input wire logic [7:0] reg_raddr,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] vin_meas,
    output logic output_enable,
    output logic uv_fault,
    output logic latched_off
);
    typedef enum logic [2:0] {
        S_RUN,
        S_DELAY,
        S_OFF,
        S_WAIT_RESTART,
        S_HOLD,
        S_LATCHED
    } iufr_state_type;

    // Registers and sequencer state
    iufr_pkg::iufr_action_type action_r;
    logic [15:0] threshold_r;
    iufr_state_type state_r;
    logic [2:0] retry_used_r;
    logic wr_action;
    logic wr_threshold;

    // Fault and retry status
    logic fault;
    logic retry_limited;
    logic retries_left;

    // Timer interface
    logic tmr_load;
    logic tmr_done;
    logic [iufr_pkg::TIMER_W-1:0] tmr_cycles;

    // Delay tables
    logic [iufr_pkg::TIMER_W-1:0] shut_table [8];
    logic [iufr_pkg::TIMER_W-1:0] restart_table [8];
    logic [iufr_pkg::TIMER_W-1:0] shut_cycles;
    logic [iufr_pkg::TIMER_W-1:0] restart_cycles;

    // Register file
    assign wr_action = reg_wr.wr_en && (reg_wr.addr == iufr_pkg::ACTION_OFFSET);
    assign wr_threshold = reg_wr.wr_en && (reg_wr.addr == iufr_pkg::THRESHOLD_OFFSET);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            action_r <= iufr_pkg::ACTION_RESET;
        end else if (wr_action) begin
            action_r <= reg_wr.wdata[7:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            threshold_r <= iufr_pkg::THRESHOLD_RESET;
        end else if (wr_threshold) begin
            threshold_r <= reg_wr.wdata;
        end
    end

    // Read data registered one cycle after the address
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            unique case (reg_raddr)
                iufr_pkg::ACTION_OFFSET: reg_rdata <= {8'h00, action_r};
                iufr_pkg::THRESHOLD_OFFSET: reg_rdata <= threshold_r;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    // Fault sensed as a plain unsigned compare
    assign fault = vin_meas < threshold_r;

    // Delay tables in cycles, one entry per code
    for (genvar i = 0; i < 8; i++) begin : g_delay_table
        assign shut_table[i] = iufr_pkg::TIMER_W'(
            (iufr_pkg::SHUTDOWN_MS_BASE << i) * iufr_pkg::CYC_PER_MS);
        assign restart_table[i] = iufr_pkg::TIMER_W'(
            (iufr_pkg::RESTART_MS_BASE + iufr_pkg::RESTART_MS_STEP * i)
            * iufr_pkg::CYC_PER_MS);
    end

    assign shut_cycles = shut_table[action_r.delay];
    assign restart_cycles = restart_table[action_r.delay];

    // Code 111 never runs out of retries
    assign retry_limited = (action_r.retries != iufr_pkg::RETRY_INFINITE);
    assign retries_left = !retry_limited || (retry_used_r < action_r.retries);

    always_comb begin
        tmr_load = 1'b0;
        tmr_cycles = shut_cycles;
        unique case (state_r)
            S_RUN: begin
                tmr_load = fault && (action_r.mode == iufr_pkg::IUFR_RIDE);
            end
            S_OFF: begin
                tmr_load = retries_left;
                tmr_cycles = restart_cycles;
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    // Shared timer for both delays
    iufr_timer u_timer (
        .mclk(mclk),
        .rst(rst),
        .load(tmr_load),
        .cycles(tmr_cycles),
        .done(tmr_done)
    );

    // Fault sequencing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= S_RUN;
        end else begin
            unique case (state_r)
                S_RUN: begin
                    if (fault) begin
                        unique case (action_r.mode)
                            iufr_pkg::IUFR_IGNORE: state_r <= S_RUN;
                            iufr_pkg::IUFR_RIDE: state_r <= S_DELAY;
                            iufr_pkg::IUFR_SHUT: state_r <= S_OFF;
                            iufr_pkg::IUFR_HOLD: state_r <= S_HOLD;
                        endcase
                    end
                end
                S_DELAY: begin
                    // Mode rewritten mid-delay takes over at once
                    if (!fault) begin
                        state_r <= S_RUN;
                    end else if (action_r.mode == iufr_pkg::IUFR_IGNORE) begin
                        state_r <= S_RUN;
                    end else if (action_r.mode == iufr_pkg::IUFR_SHUT) begin
                        state_r <= S_OFF;
                    end else if (action_r.mode == iufr_pkg::IUFR_HOLD) begin
                        state_r <= S_HOLD;
                    end else if (tmr_done) begin
                        state_r <= S_OFF;
                    end
                end
                S_OFF: begin
                    // Out of retries latches off until reset
                    state_r <= retries_left ? S_WAIT_RESTART : S_LATCHED;
                end
                S_WAIT_RESTART: begin
                    if (tmr_done) begin
                        state_r <= S_RUN;
                    end
                end
                S_HOLD: begin
                    if (!fault) begin
                        state_r <= S_RUN;
                    end
                end
                S_LATCHED: state_r <= S_LATCHED;
                default: state_r <= S_RUN;
            endcase
        end
    end

    // Retries counted until the output runs a full clean cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            retry_used_r <= 3'h0;
        end else if (state_r == S_OFF && retries_left && retry_limited) begin
            // Unlimited retries leave the count alone
            retry_used_r <= retry_used_r + 3'h1;
        end else if (state_r == S_RUN && !fault) begin
            retry_used_r <= 3'h0;
        end
    end

    // Output runs in normal operation and during the ride-through delay
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= (state_r == S_RUN) || (state_r == S_DELAY);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            uv_fault <= 1'b0;
        end else begin
            uv_fault <= fault;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            latched_off <= 1'b0;
        end else begin
            latched_off <= (state_r == S_LATCHED);
        end
    end
endmodule : iufr_seq

// ---- dv/iufr_props.sv ----
// Port checker for the fault sequencer
module iufr_props (
    input wire logic mclk,
    input wire logic rst,
    input iufr_pkg::iufr_reg_wr_type reg_wr,
    input wire logic [7:0] reg_raddr,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] vin_meas,
    input wire logic output_enable,
    input wire logic uv_fault,
    input wire logic latched_off
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] act_r;
    logic [15:0] thr_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) act_r <= 8'h00;
        else if (reg_wr.wr_en && reg_wr.addr == 8'h5A) act_r <= reg_wr.wdata[7:0];
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) thr_r <= 16'h0000;
        else if (reg_wr.wr_en && reg_wr.addr == 8'h59) thr_r <= reg_wr.wdata;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_fault_compare: assert property (1 |=> uv_fault == ($past(vin_meas) < $past(thr_r)))
        else $error("fault flag wrong");
    a_action_read: assert property (reg_raddr == 8'h5A |=> reg_rdata == {8'h00, $past(act_r)})
        else $error("action read wrong");
    a_ignore_mode: assert property (act_r[7:6] == 2'h0 && output_enable |=> output_enable)
        else $error("mode 00 acted");
    a_ride_delay: assert property (act_r[7:6] == 2'h1 && $rose(uv_fault) && output_enable
        |-> output_enable [*8])
        else $error("early shutdown");
    a_shut_fast: assert property (act_r[7:6] == 2'h2 && uv_fault |-> ##[1:3] !output_enable)
        else $error("no prompt shutdown");
    a_zero_retry: assert property (act_r[7:3] == 5'h10 && uv_fault |-> ##[1:4] latched_off)
        else $error("no latch");
    a_hold_off: assert property (act_r[7:6] == 2'h3 && uv_fault |-> ##[1:3] !output_enable)
        else $error("output not held off");
    a_hold_back: assert property (act_r[7:6] == 2'h3 && $fell(uv_fault) |-> ##[1:4] output_enable)
        else $error("output not restored");
    a_latch_kept: assert property (latched_off |=> latched_off && !output_enable)
        else $error("latch released");
endmodule : iufr_props
bind iufr_seq iufr_props u_props (
    .mclk(mclk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .vin_meas(vin_meas),
    .output_enable(output_enable),
    .uv_fault(uv_fault),
    .latched_off(latched_off)
);

// ---- dv/iufr_host.sv ----
// Host model: register access and measured input voltage
module iufr_host (
    input wire logic mclk,
    input wire logic [15:0] reg_rdata,
    output iufr_pkg::iufr_reg_wr_type reg_wr,
    output logic [7:0] reg_raddr,
    output logic [15:0] vin_meas
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = '0;
        reg_raddr = 8'h00;
        vin_meas = 16'h0200;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk) #1;
        reg_wr = '{wr_en: 1'b1, addr: a, wdata: d};
        @(posedge mclk) #1;
        reg_wr.wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk) #1;
        reg_raddr = a;
        repeat (2) @(posedge mclk);
        #1 d = reg_rdata;
    endtask : rd
    task automatic vin(input logic [15:0] v);
        @(posedge mclk) #1;
        vin_meas = v;
    endtask : vin
endmodule : iufr_host

// ---- dv/input_uv_fault_response_test.sv ----
// Self-checking bench for the fault sequencer
module input_uv_fault_response_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    iufr_pkg::iufr_reg_wr_type reg_wr;
    logic [7:0] reg_raddr;
    logic [15:0] reg_rdata, vin_meas, v;
    logic output_enable, uv_fault, latched_off;
    int errors = 0;
    int n_checks = 0;
    initial forever #2 mclk = ~mclk;
    iufr_host host (
        .mclk(mclk),
        .reg_rdata(reg_rdata),
        .reg_wr(reg_wr),
        .reg_raddr(reg_raddr),
        .vin_meas(vin_meas)
    );
    iufr_seq DUT (
        .mclk(mclk),
        .rst(rst),
        .reg_wr(reg_wr),
        .reg_raddr(reg_raddr),
        .reg_rdata(reg_rdata),
        .vin_meas(vin_meas),
        .output_enable(output_enable),
        .uv_fault(uv_fault),
        .latched_off(latched_off)
    );
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle
    task automatic flags(input logic [2:0] e);
        cmp({13'h0000, output_enable, uv_fault, latched_off}, {13'h0000, e});
    endtask : flags
    task automatic reset_dut;
        rst = 1'b1;
        idle(16);
        rst = 1'b0;
        idle(2);
    endtask : reset_dut
    task automatic complete_run;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    initial begin
        reset_dut;
        flags(3'h4);
        host.wr(8'h59, 16'h0100);
        host.rd(8'h59, v);
        cmp(v, 16'h0100);
        host.rd(8'h5B, v);
        cmp(v, 16'h0000);
        host.vin(16'h00FF);
        idle(6);
        flags(3'h6);
        host.wr(8'h5A, 16'h007F);
        idle(40);
        flags(3'h6);
        host.vin(16'h0200);
        idle(6);
        flags(3'h4);
        host.vin(16'h00FF);
        idle(12);
        flags(3'h6);
        host.vin(16'h0200);
        idle(6);
        flags(3'h4);
        host.wr(8'h5A, 16'hFF80);
        host.rd(8'h5A, v);
        cmp(v, 16'h0080);
        host.vin(16'h00FF);
        idle(6);
        flags(3'h3);
        host.vin(16'h0200);
        idle(8);
        flags(3'h1);
        reset_dut;
        host.rd(8'h5A, v);
        cmp(v, 16'h0000);
        host.wr(8'h59, 16'h0100);
        host.wr(8'h5A, 16'h00C0);
        host.vin(16'h00FF);
        idle(6);
        flags(3'h2);
        host.vin(16'h0200);
        idle(6);
        flags(3'h4);
        host.wr(8'h5A, 16'h0088);
        host.vin(16'h00FF);
        idle(6);
        flags(3'h2);
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        complete_run;
    end
endmodule : input_uv_fault_response_test
